// ==== hdl/scpm_pkg.sv ====
package scpm_pkg;
    // ****************************************
    // selector codes and timing
    // ****************************************
    localparam logic [2:0] SEL_FULL = 3'h0;
    localparam logic [2:0] SEL_DIV64 = 3'h6;
    localparam logic [2:0] SEL_SLOW = 3'h7;
    localparam logic [2:0] SEL_RST = 3'h0;
    localparam logic HS_KEEP_RST = 1'h0;
    localparam logic LS_KEEP_RST = 1'h0;
    localparam logic FAST_EN_RST = 1'h1;
    localparam int FAST_OSC_KHZ = 20000;
    localparam int SLOW_OSC_KHZ = 32;
    localparam int CORE_CLK_KHZ = 10000;
    // slow tick period in core cycles, rounded down
    localparam int SLOW_DIV = CORE_CLK_KHZ / SLOW_OSC_KHZ;
    localparam int STABLE_CYC = 64;

    typedef enum logic [4:0] {
        MODE_RUN = 5'h01,
        MODE_SLEEP = 5'h02,
        MODE_IDLE_LOW = 5'h04,
        MODE_IDLE_BOTH = 5'h08,
        MODE_IDLE_HIGH = 5'h10
    } scpm_mode_t;

    typedef struct packed {
        logic [2:0] sys_clk_select;
        logic hs_osc_keep_on_halt;
        logic ls_osc_keep_on_halt;
        logic fast_osc_enable;
    } scpm_cfg_t;

    typedef struct packed {
        logic system_clock_out;
        logic f_high;
        logic f_low;
        logic slow_osc_clock;
        logic cpu_run;
        logic fast_osc_stable_flag;
        logic fast_mode;
    } scpm_stat_t;
endpackage : scpm_pkg

// ==== hdl/scpm_ctrl.sv ====
`timescale 1ns/1ps
module scpm_ctrl #(
    parameter int STABLE_CYC = scpm_pkg::STABLE_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // software configuration
    input wire scpm_pkg::scpm_cfg_t cfg_in,
    input wire logic cfg_we,
    input wire logic watchdog_enable,
    // cpu events
    input wire logic halt_exec,
    input wire logic wake_req,
    // clock and status outputs
    output scpm_pkg::scpm_stat_t stat,
    output scpm_pkg::scpm_mode_t mode,
    output logic wdt_clk_en,
    output logic timebase_clk_en
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        scpm_pkg::scpm_cfg_t cfg;
        scpm_pkg::scpm_mode_t mode;
        logic [5:0] div;
        logic [15:0] slow_cnt;
        logic slow_tick;
        logic [15:0] stab_cnt;
        logic stable;
        scpm_pkg::scpm_stat_t stat;
    } scpm_state_t;

    scpm_state_t r;
    scpm_state_t next_r;

    function automatic logic div_tap(input logic [2:0] sel,
                                     input logic [5:0] d);
        logic [5:0] mask;
        // one pulse per 2^sel cycles: low sel bits all ones
        // a plain bit tap would give a 50% duty, not a single enable
        mask = 6'h3f >> (3'h6 - sel);
        div_tap = ((d & mask) == mask);
    endfunction : div_tap

    logic fast_run;
    logic slow_run;
    logic lf_feed;
    logic sel_slow;

    always_comb begin
        next_r = r;
        sel_slow = (r.cfg.sys_clk_select == scpm_pkg::SEL_SLOW);
        // ****************************************
        // oscillator run state per mode
        // ****************************************
        unique case (r.mode)
            scpm_pkg::MODE_RUN: begin
                fast_run = r.cfg.fast_osc_enable | ~sel_slow;
                lf_feed = 1'b1;
                slow_run = 1'b1;
            end
            scpm_pkg::MODE_SLEEP: begin
                fast_run = 1'b0;
                lf_feed = 1'b0;
                slow_run = watchdog_enable;
            end
            scpm_pkg::MODE_IDLE_LOW: begin
                fast_run = 1'b0;
                lf_feed = 1'b1;
                slow_run = 1'b1;
            end
            scpm_pkg::MODE_IDLE_BOTH: begin
                fast_run = 1'b1;
                lf_feed = 1'b1;
                slow_run = 1'b1;
            end
            scpm_pkg::MODE_IDLE_HIGH: begin
                fast_run = 1'b1;
                lf_feed = 1'b0;
                slow_run = 1'b1;
            end
            default: begin
                fast_run = 1'b0;
                lf_feed = 1'b0;
                slow_run = 1'b0;
            end
        endcase
        // ****************************************
        // oscillators: core clock stands for the fast source, at the 10MHz core rate
        // ****************************************
        // the fast divider steps each core cycle as an f_high enable
        if (fast_run && r.stable) begin
            next_r.div = r.div + 6'h01;
        end
        next_r.slow_tick = 1'b0;
        if (slow_run) begin
            if (r.slow_cnt == 16'(scpm_pkg::SLOW_DIV - 1)) begin
                next_r.slow_cnt = 16'h0000;
                next_r.slow_tick = 1'b1;
            end else begin
                next_r.slow_cnt = r.slow_cnt + 16'h0001;
            end
        end
        // stability: held cleared while stopped, counts up while running
        if (!fast_run) begin
            next_r.stable = 1'b0;
            next_r.stab_cnt = 16'h0000;
        end else if (!r.stable) begin
            if (r.stab_cnt == 16'(STABLE_CYC - 1)) begin
                next_r.stable = 1'b1;
            end else begin
                next_r.stab_cnt = r.stab_cnt + 16'h0001;
            end
        end
        // ****************************************
        // mode sequencing
        // ****************************************
        if (r.mode == scpm_pkg::MODE_RUN) begin
            if (cfg_we) begin
                next_r.cfg = cfg_in;
            end
            if (halt_exec) begin
                unique case ({r.cfg.hs_osc_keep_on_halt,
                              r.cfg.ls_osc_keep_on_halt})
                    2'b00: next_r.mode = scpm_pkg::MODE_SLEEP;
                    2'b01: next_r.mode = scpm_pkg::MODE_IDLE_LOW;
                    2'b11: next_r.mode = scpm_pkg::MODE_IDLE_BOTH;
                    2'b10: next_r.mode = scpm_pkg::MODE_IDLE_HIGH;
                endcase
            end
        end else if (wake_req) begin
            next_r.mode = scpm_pkg::MODE_RUN;
        end
        // ****************************************
        // clock enables out
        // ****************************************
        next_r.stat.f_high = fast_run & r.stable;
        next_r.stat.f_low = lf_feed & r.slow_tick;
        next_r.stat.slow_osc_clock = r.slow_tick;
        next_r.stat.cpu_run = (r.mode == scpm_pkg::MODE_RUN);
        next_r.stat.fast_osc_stable_flag = r.stable;
        next_r.stat.fast_mode = ~sel_slow;
        if (sel_slow) begin
            // idle low passes, idle high stops here via lf_feed
            next_r.stat.system_clock_out = lf_feed & r.slow_tick;
        end else begin
            next_r.stat.system_clock_out = fast_run & r.stable
                & div_tap(r.cfg.sys_clk_select, r.div);
        end
        if (r.mode != scpm_pkg::MODE_RUN
            && r.mode != scpm_pkg::MODE_IDLE_BOTH
            && r.mode != scpm_pkg::MODE_IDLE_LOW
            && r.mode != scpm_pkg::MODE_IDLE_HIGH) begin
            next_r.stat.system_clock_out = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            r.cfg.sys_clk_select <= scpm_pkg::SEL_RST;
            r.cfg.hs_osc_keep_on_halt <= scpm_pkg::HS_KEEP_RST;
            r.cfg.ls_osc_keep_on_halt <= scpm_pkg::LS_KEEP_RST;
            r.cfg.fast_osc_enable <= scpm_pkg::FAST_EN_RST;
            r.mode <= scpm_pkg::MODE_RUN;
            r.div <= 6'h00;
            r.slow_cnt <= 16'h0000;
            r.slow_tick <= 1'b0;
            r.stab_cnt <= 16'h0000;
            r.stable <= 1'b0;
            r.stat <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign stat = r.stat;
    assign mode = r.mode;
    // watchdog and time base run from the slow oscillator tick
    assign wdt_clk_en = r.stat.slow_osc_clock;
    assign timebase_clk_en = r.stat.slow_osc_clock;

    // ****************************************
    // checks
    // ****************************************
    a_sleep_no_clk: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        r.mode == scpm_pkg::MODE_SLEEP
            |=> !stat.system_clock_out && !stat.f_high)
        else $error("clock seen in sleep");
    a_sleep_wdt_off: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (r.mode == scpm_pkg::MODE_SLEEP && !watchdog_enable)[*2]
            |=> !stat.slow_osc_clock)
        else $error("slow clock runs in sleep without watchdog");
    a_halt_only: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        r.mode == scpm_pkg::MODE_RUN && !halt_exec
            |=> r.mode == scpm_pkg::MODE_RUN)
        else $error("power-down without halt");
    a_idle_low: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        r.mode == scpm_pkg::MODE_RUN && halt_exec
            && !r.cfg.hs_osc_keep_on_halt && r.cfg.ls_osc_keep_on_halt
            |=> r.mode == scpm_pkg::MODE_IDLE_LOW)
        else $error("wrong mode for keep 01");
    a_idle_both: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        r.mode == scpm_pkg::MODE_RUN && halt_exec
            && r.cfg.hs_osc_keep_on_halt && r.cfg.ls_osc_keep_on_halt
            |=> r.mode == scpm_pkg::MODE_IDLE_BOTH)
        else $error("wrong mode for keep 11");
    a_idle_high: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        r.mode == scpm_pkg::MODE_RUN && halt_exec
            && r.cfg.hs_osc_keep_on_halt && !r.cfg.ls_osc_keep_on_halt
            |=> r.mode == scpm_pkg::MODE_IDLE_HIGH)
        else $error("wrong mode for keep 10");
    a_idle_high_gate: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        r.mode == scpm_pkg::MODE_IDLE_HIGH && sel_slow
            |=> !stat.system_clock_out && !stat.f_low)
        else $error("clock out while source stopped");
    a_stable_rise: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $rose(r.stable) |-> $past(r.stab_cnt) == 16'(STABLE_CYC - 1))
        else $error("stable flag set early");
    a_fast_running: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        r.mode == scpm_pkg::MODE_RUN && !sel_slow && r.stable
            |=> r.div == $past(r.div) + 6'h01)
        else $error("fast divider stalled in fast mode");
endmodule : scpm_ctrl

// ==== testbench/scpm_ctrl_tb.sv ====
`timescale 1ns/1ps
module scpm_ctrl_tb;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    // short settle count keeps the run small
    localparam int STB = 4;
    localparam int SW = 2 * scpm_pkg::SLOW_DIV;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    scpm_pkg::scpm_cfg_t cfg_in = 6'h01;
    logic cfg_we = 1'b0;
    logic watchdog_enable = 1'b1;
    logic halt_exec = 1'b0;
    logic wake_req = 1'b0;
    scpm_pkg::scpm_stat_t stat;
    scpm_pkg::scpm_mode_t mode;
    logic wdt_clk_en;
    logic timebase_clk_en;
    int mismatches = 0;
    int check_count = 0;
    int n_sys, n_low, n_slow, n_bad;

    always #50 core_clk = ~core_clk;

    scpm_ctrl #(.STABLE_CYC(STB)) u_scpm_ctrl (
        .core_clk(core_clk), .rst_n(rst_n), .cfg_in(cfg_in),
        .cfg_we(cfg_we), .watchdog_enable(watchdog_enable),
        .halt_exec(halt_exec), .wake_req(wake_req), .stat(stat),
        .mode(mode), .wdt_clk_en(wdt_clk_en),
        .timebase_clk_en(timebase_clk_en)
    );

    // ****************************************
    // shared helpers
    // ****************************************
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cycles

    // pulses counted after the edge has settled
    task automatic count(input int n);
        n_sys = 0;
        n_low = 0;
        n_slow = 0;
        n_bad = 0;
        repeat (n) begin
            @(posedge core_clk);
            #1;
            n_sys += (stat.system_clock_out === 1'b1);
            n_low += (stat.f_low === 1'b1);
            n_slow += (stat.slow_osc_clock === 1'b1);
            n_bad += (wdt_clk_en !== stat.slow_osc_clock);
            n_bad += (timebase_clk_en !== stat.slow_osc_clock);
        end
    endtask : count

    task automatic wr_cfg(input logic [2:0] sel, input logic hs, ls, en);
        @(posedge core_clk);
        cfg_in <= '{sel, hs, ls, en};
        cfg_we <= 1'b1;
        @(posedge core_clk);
        cfg_we <= 1'b0;
    endtask : wr_cfg

    task automatic halt_then_wait;
        @(posedge core_clk);
        halt_exec <= 1'b1;
        @(posedge core_clk);
        halt_exec <= 1'b0;
        cycles(3);
    endtask : halt_then_wait

    task automatic wake;
        @(posedge core_clk);
        wake_req <= 1'b1;
        @(posedge core_clk);
        wake_req <= 1'b0;
        cycles(3);
        #1;
        chk("mode after wake", scpm_pkg::MODE_RUN, mode);
        chk("cpu_run after wake", 1, stat.cpu_run);
    endtask : wake

    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_reset;
        #1;
        chk("stat in reset", 0, stat);
        chk("mode in reset", scpm_pkg::MODE_RUN, mode);
        @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        #1;
        chk("stable flag early", 0, stat.fast_osc_stable_flag);
        cycles(STB + 4);
        #1;
        chk("stable flag late", 1, stat.fast_osc_stable_flag);
        chk("f_high on", 1, stat.f_high);
    endtask : test_reset

    task automatic test_divide;
        for (int s = 0; s < 7; s++) begin
            wr_cfg(s[2:0], 1'b0, 1'b0, 1'b1);
            cycles(8);
            count(128);
            chk("sys pulses", 128 >> s, n_sys);
            count(SW);
            chk("f_low pulses fast", 2, n_low);
            chk("slow pulses fast", 2, n_slow);
            chk("wdt and timebase", 0, n_bad);
        end
    endtask : test_divide

    task automatic test_slow;
        wr_cfg(3'h7, 1'b0, 1'b0, 1'b1);
        cycles(8);
        count(SW);
        chk("sys pulses slow", 2, n_sys);
        chk("fast_mode slow", 0, stat.fast_mode);
        chk("f_high kept", 1, stat.f_high);
        wr_cfg(3'h7, 1'b0, 1'b0, 1'b0);
        cycles(4);
        #1;
        chk("f_high stopped", 0, stat.f_high);
        wr_cfg(3'h0, 1'b0, 1'b0, 1'b1);
        @(posedge core_clk);
        #1;
        chk("flag restart", 0, stat.fast_osc_stable_flag);
        cycles(STB + 4);
        #1;
        chk("flag restarted", 1, stat.fast_osc_stable_flag);
        chk("fast_mode back", 1, stat.fast_mode);
    endtask : test_slow

    task automatic test_halt;
        logic [1:0] kp [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
        scpm_pkg::scpm_mode_t em [4] = '{scpm_pkg::MODE_SLEEP,
            scpm_pkg::MODE_IDLE_LOW, scpm_pkg::MODE_IDLE_BOTH,
            scpm_pkg::MODE_IDLE_HIGH};
        for (int k = 0; k < 4; k++) begin
            wr_cfg(3'h0, kp[k][1], kp[k][0], 1'b1);
            cycles(STB + 8);
            halt_then_wait();
            #1;
            chk("halt mode", em[k], mode);
            chk("cpu stopped", 0, stat.cpu_run);
            chk("f_high halt", kp[k][1], stat.f_high);
            count(SW);
            chk("sys halt", kp[k][1] ? SW : 0, n_sys);
            chk("f_low halt", kp[k][0] ? 2 : 0, n_low);
            chk("slow wdt on", 2, n_slow);
            wr_cfg(3'h7, 1'b0, 1'b0, 1'b0);
            wake();
            chk("write refused", 1, stat.fast_mode);
        end
    endtask : test_halt

    task automatic test_idle_slow;
        for (int k = 0; k < 2; k++) begin
            wr_cfg(3'h7, k[0], ~k[0], 1'b1);
            cycles(STB + 8);
            halt_then_wait();
            count(SW);
            chk("sys idle slow", k ? 0 : 2, n_sys);
            wake();
        end
    endtask : test_idle_slow

    task automatic test_sleep_nowdt;
        wr_cfg(3'h0, 1'b0, 1'b0, 1'b1);
        cycles(STB + 8);
        watchdog_enable <= 1'b0;
        halt_then_wait();
        count(SW);
        chk("slow wdt off", 0, n_slow);
        wake();
        watchdog_enable <= 1'b1;
    endtask : test_sleep_nowdt

    // ****************************************
    // sequence, watchdog and verdict
    // ****************************************
    task automatic wrap_up;
        if (mismatches == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    initial begin
        cycles(6);
        test_reset();
        test_divide();
        test_slow();
        test_halt();
        test_idle_slow();
        test_sleep_nowdt();
        wrap_up();
    end

    initial begin
        #(100 * 40000);
        mismatches++;
        wrap_up();
    end
endmodule : scpm_ctrl_tb
